// File: core/sprr_pkg.sv
`default_nettype none
package sprr_pkg;
   // ---------------------------------------------------------------
   // Command and state codes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SPRR_NOP   = 3'b000,
      SPRR_MRS   = 3'b001,
      SPRR_READ  = 3'b010,
      SPRR_WRITE = 3'b011,
      SPRR_ACT   = 3'b100,
      SPRR_PRE   = 3'b101,
      SPRR_REF   = 3'b110,
      SPRR_OTHER = 3'b111
   } sprr_cmd_e;
   typedef enum logic [1:0] {
      SPRR_IDLE  = 2'b00,
      SPRR_WAIT  = 2'b01,
      SPRR_BURST = 2'b10
   } sprr_state_e;
   // ---------------------------------------------------------------
   // Mode register selects and field positions
   // ---------------------------------------------------------------
   localparam logic [2:0] SPRR_MR0_SEL    = 3'h0;
   localparam logic [2:0] SPRR_MR3_SEL    = 3'h3;
   localparam int         SPRR_EN_BIT     = 2;
   localparam int         SPRR_LOC_LSB    = 0;
   localparam int         SPRR_BL_LSB     = 0;
   localparam int         SPRR_AP_BIT     = 10;
   localparam int         SPRR_BC_BIT     = 12;
   localparam logic [1:0] SPRR_BL_FIX8    = 2'h0;
   localparam logic [1:0] SPRR_BL_OTF     = 2'h1;
   localparam logic [1:0] SPRR_BL_FIX4    = 2'h2;
   localparam logic [1:0] SPRR_LOC_CAL    = 2'h0;
   // ---------------------------------------------------------------
   // Pattern, burst counts and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] SPRR_CAL_PAT    = 8'hAA;
   localparam logic [3:0] SPRR_BEATS8     = 4'h8;
   localparam logic [3:0] SPRR_BEATS4     = 4'h4;
   localparam logic [1:0] SPRR_RST_BL     = SPRR_BL_FIX8;
   localparam logic [1:0] SPRR_RST_LOC    = 2'h0;
   localparam logic       SPRR_RST_EN     = 1'b0;
endpackage
`default_nettype wire

// File: core/sprr_core.sv
`timescale 1ns/100ps
`default_nettype none
module sprr_core
   import sprr_pkg::*;
#(
   parameter int LAT_W = 5
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             clk_en,
   input  wire logic             cmd_valid,
   input  wire sprr_cmd_e        cmd_code,
   input  wire logic [2:0]       cmd_bank,
   input  wire logic [15:0]      cmd_addr,
   input  wire logic [LAT_W-1:0] rd_latency,
   input  wire logic             lane_repeat,
   input  wire logic [15:0]      arr_data,
   output logic                  arr_req,
   output logic [2:0]            arr_bank,
   output logic [9:0]            arr_col,
   output logic [2:0]            arr_beat,
   output logic                  precharge_req,
   output logic                  array_write,
   output logic                  cmd_refused,
   output logic                  pattern_on,
   output logic [1:0]            pattern_loc,
   output logic [15:0]           dq_out,
   output logic                  dq_valid
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic chop_of(input logic [1:0] mode,
                                    input logic       a12);
      chop_of = (mode == SPRR_BL_FIX4) ||
                ((mode == SPRR_BL_OTF) && !a12);
   endfunction
   function automatic logic [7:0] lane_of(input logic b,
                                          input logic rep);
      lane_of = rep ? {8{b}} : {7'h00, b};
   endfunction
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   sprr_state_e      state_q, state_d;
   logic             en_q, en_d;
   logic [1:0]       loc_q, loc_d;
   logic [1:0]       bl_q, bl_d;
   logic             pat_q, pat_d;
   logic             chop_q, chop_d;
   logic [2:0]       beat_q, beat_d;
   logic [3:0]       rem_q, rem_d;
   logic [LAT_W-1:0] lat_q, lat_d;
   logic             areq_q, areq_d;
   logic [2:0]       abank_q, abank_d;
   logic [9:0]       acol_q, acol_d;
   logic             ap_q, ap_d;
   logic             wr_q, wr_d;
   logic             ref_q, ref_d;
   logic [15:0]      dq_q, dq_d;
   logic             dv_q, dv_d;
   logic             is_rd;
   logic             is_mrs3;
   logic             is_mrs0;
   logic             start;
   logic             burst_w;
   logic             pbit;
   assign is_rd   = cmd_valid && (cmd_code == SPRR_READ);
   assign is_mrs3 = cmd_valid && (cmd_code == SPRR_MRS) &&
                    (cmd_bank == SPRR_MR3_SEL);
   assign is_mrs0 = cmd_valid && (cmd_code == SPRR_MRS) &&
                    (cmd_bank == SPRR_MR0_SEL);
   assign start   = is_rd && (state_q == SPRR_IDLE);
   assign burst_w = (state_q == SPRR_BURST);
   // Reserved locations return zero but keep ordering
   assign pbit    = (loc_q == SPRR_LOC_CAL) &&
                    SPRR_CAL_PAT[beat_q];
   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      en_d    = en_q;
      loc_d   = loc_q;
      bl_d    = bl_q;
      pat_d   = pat_q;
      chop_d  = chop_q;
      beat_d  = beat_q;
      rem_d   = rem_q;
      lat_d   = lat_q;
      areq_d  = 1'b0;
      abank_d = abank_q;
      acol_d  = acol_q;
      ap_d    = 1'b0;
      wr_d    = 1'b0;
      ref_d   = 1'b0;
      dq_d    = dq_q;
      dv_d    = 1'b0;
      if (is_mrs3) begin
         en_d  = cmd_addr[SPRR_EN_BIT];
         loc_d = cmd_addr[SPRR_LOC_LSB +: 2];
      end
      if (is_mrs0) begin
         bl_d = cmd_addr[SPRR_BL_LSB +: 2];
      end
      if (cmd_valid && en_q && (cmd_code != SPRR_READ) &&
          (cmd_code != SPRR_MRS) && (cmd_code != SPRR_NOP)) begin
         ref_d = 1'b1;
      end
      if (cmd_valid && !en_q && (cmd_code == SPRR_WRITE)) begin
         wr_d = 1'b1;
      end
      case (state_q)
         SPRR_IDLE: begin
            if (start) begin
               pat_d  = en_q;
               chop_d = chop_of(bl_q, cmd_addr[SPRR_BC_BIT]);
               // Only bit 2 of the column picks the start beat
               beat_d = chop_d ? {cmd_addr[2], 2'b00}
                               : 3'b000;
               rem_d  = chop_d ? SPRR_BEATS4 : SPRR_BEATS8;
               if (!en_q) begin
                  areq_d  = 1'b1;
                  abank_d = cmd_bank;
                  acol_d  = cmd_addr[9:0];
                  ap_d    = cmd_addr[SPRR_AP_BIT];
               end
               // Same latency for both sources
               if (rd_latency <= LAT_W'(1)) begin
                  state_d = SPRR_BURST;
               end else begin
                  lat_d   = rd_latency - LAT_W'(1);
                  state_d = SPRR_WAIT;
               end
            end
         end
         SPRR_WAIT: begin
            if (lat_q <= LAT_W'(1)) begin
               state_d = SPRR_BURST;
            end else begin
               lat_d = lat_q - LAT_W'(1);
            end
         end
         SPRR_BURST: begin
            dv_d = 1'b1;
            if (pat_q) begin
               dq_d = {lane_of(pbit, lane_repeat),
                       lane_of(pbit, lane_repeat)};
            end else begin
               dq_d = arr_data;
            end
            beat_d = beat_q + 3'h1;
            rem_d  = rem_q - 4'h1;
            if (rem_q == 4'h1) begin
               state_d = SPRR_IDLE;
            end
         end
         default: begin
            state_d = SPRR_IDLE;
         end
      endcase
   end
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Asynchronous reset clears pattern mode too
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SPRR_IDLE;
         en_q    <= SPRR_RST_EN;
         loc_q   <= SPRR_RST_LOC;
         bl_q    <= SPRR_RST_BL;
         pat_q   <= 1'b0;
         chop_q  <= 1'b0;
         beat_q  <= 3'h0;
         rem_q   <= 4'h0;
         lat_q   <= '0;
         areq_q  <= 1'b0;
         abank_q <= 3'h0;
         acol_q  <= 10'h000;
         ap_q    <= 1'b0;
         wr_q    <= 1'b0;
         ref_q   <= 1'b0;
         dq_q    <= 16'h0000;
         dv_q    <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         en_q    <= en_d;
         loc_q   <= loc_d;
         bl_q    <= bl_d;
         pat_q   <= pat_d;
         chop_q  <= chop_d;
         beat_q  <= beat_d;
         rem_q   <= rem_d;
         lat_q   <= lat_d;
         areq_q  <= areq_d;
         abank_q <= abank_d;
         acol_q  <= acol_d;
         ap_q    <= ap_d;
         wr_q    <= wr_d;
         ref_q   <= ref_d;
         dq_q    <= dq_d;
         dv_q    <= dv_d;
      end
   end
   assign arr_req       = areq_q;
   assign arr_bank      = abank_q;
   assign arr_col       = acol_q;
   assign arr_beat      = beat_q;
   assign precharge_req = ap_q;
   assign array_write   = wr_q;
   assign cmd_refused   = ref_q;
   assign pattern_on    = en_q;
   assign pattern_loc   = loc_q;
   assign dq_out        = dq_q;
   assign dq_valid      = dv_q;
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n || !clk_en);
   sequence s_burst_start;
      $rose(burst_w);
   endsequence
   sequence s_eight;
      burst_w [*8] ##1 !burst_w;
   endsequence
   sequence s_four;
      burst_w [*4] ##1 !burst_w;
   endsequence
   property p_enable;
      is_mrs3 |=> (en_q == $past(cmd_addr[SPRR_EN_BIT]));
   endproperty
   a_enable: assert property (p_enable)
      else $error("pattern enable not taken from mode set");
   property p_no_array;
      (start && en_q) |=> !arr_req;
   endproperty
   a_no_array: assert property (p_no_array)
      else $error("array read issued in pattern mode");
   property p_no_pre;
      (start && en_q) |=> !precharge_req;
   endproperty
   a_no_pre: assert property (p_no_pre)
      else $error("precharge issued in pattern mode");
   property p_pat_bit;
      (burst_w && pat_q && (loc_q == SPRR_LOC_CAL)) |=>
         (dq_out[0] == SPRR_CAL_PAT[$past(beat_q)]);
   endproperty
   a_pat_bit: assert property (p_pat_bit)
      else $error("pattern bit wrong for beat");
   property p_lanes;
      (dq_valid && $past(pat_q)) |->
         (dq_out[7:0] == dq_out[15:8]) &&
         ((dq_out[7:1] == 7'h00) || (dq_out[7:1] == {7{dq_out[0]}}));
   endproperty
   a_lanes: assert property (p_lanes)
      else $error("byte lanes do not follow pattern bit");
   property p_len8;
      (s_burst_start and !chop_q) |-> s_eight;
   endproperty
   a_len8: assert property (p_len8)
      else $error("full burst not eight beats");
   property p_len4;
      (s_burst_start and chop_q) |-> s_four;
   endproperty
   a_len4: assert property (p_len4)
      else $error("chopped burst not four beats");
   property p_chop_mode;
      (start && (bl_q == SPRR_BL_OTF)) |=>
         (chop_q == !$past(cmd_addr[SPRR_BC_BIT]));
   endproperty
   a_chop_mode: assert property (p_chop_mode)
      else $error("on-the-fly chop select wrong");
   property p_write;
      (cmd_valid && (cmd_code == SPRR_WRITE) && !en_q) |=> array_write;
   endproperty
   a_write: assert property (p_write)
      else $error("normal write not sent to array");
   property p_lat;
      (start && (rd_latency == LAT_W'(3))) |=>
         !burst_w ##1 !burst_w ##1 burst_w;
   endproperty
   a_lat: assert property (p_lat)
      else $error("burst start does not follow latency");
endmodule
`default_nettype wire

// File: bench/sprr_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module sprr_ctrl_model
   import sprr_pkg::*;
#(
   parameter int LOCK_CYC = 20,
   parameter int GAP_CYC  = 4
) (
   input  wire logic        core_clk,
   output var  logic        cmd_valid,
   output var  sprr_cmd_e   cmd_code,
   output var  logic [2:0]  cmd_bank,
   output var  logic [15:0] cmd_addr
);
   int   cyc = 0;
   logic mode_on = 1'b0;
   logic [15:0] mr3_val = 16'h0000;
   initial begin
      cmd_valid = 1'b0;
      cmd_code  = SPRR_NOP;
      cmd_bank  = 3'h0;
      cmd_addr  = 16'h0000;
   end
   always @(posedge core_clk) cyc <= cyc + 1;
   // -----------------------------------------
   // One command, then lines left scrambled
   // -----------------------------------------
   task automatic send(input sprr_cmd_e c, input logic [2:0] b,
                       input logic [15:0] a);
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b1;
      cmd_code  = c;
      cmd_bank  = b;
      cmd_addr  = a;
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b0;
      cmd_code  = SPRR_NOP;
      cmd_bank  = ~b;
      cmd_addr  = ~a;
   endtask
   task automatic put(input logic [2:0] sel, input logic [15:0] a);
      repeat (GAP_CYC) @(posedge core_clk);
      if (sel == SPRR_MR3_SEL && a[SPRR_EN_BIT] && !mode_on) begin
         send(SPRR_PRE, 3'h0, 16'h0400);
         repeat (GAP_CYC) @(posedge core_clk);
      end
      send(SPRR_MRS, sel, a);
      // While on, rd and put send only rd and mrs; t_refuse uses send for other commands
      if (sel == SPRR_MR3_SEL) begin
         mode_on = a[SPRR_EN_BIT];
         mr3_val = a;
      end
   endtask
   // Other mode sets only with pattern mode left
   task automatic mode_set_command(input logic [2:0] sel, input logic [15:0] a);
      logic [15:0] keep;
      keep = mr3_val;
      if (mode_on && (sel != SPRR_MR3_SEL)) begin
         put(SPRR_MR3_SEL, 16'h0000);
         put(sel, a);
         put(SPRR_MR3_SEL, keep);
      end else begin
         put(sel, a);
      end
   endtask
   task automatic rd(input logic [2:0] b, input logic a12, input logic a2,
                     input logic ap, input logic [6:0] col);
      while (cyc < LOCK_CYC) @(posedge core_clk);
      send(SPRR_READ, b,
           {3'h0, a12, 1'b1, ap, col, a2, 2'b00});
   endtask
endmodule
`default_nettype wire

// File: bench/sprr_pattern_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
   mismatches++; $display("CHECK FAILED %s expected %h seen %h", nm, ex, \
   got); end end
module sdram_pattern_register_readout_test;
   import sprr_pkg::*;
   localparam int LAT = 3;
   logic core_clk = 1'b0, rst_n = 1'b0, lane_repeat = 1'b1;
   logic clk_en = 1'b1;
   logic cmd_valid, arr_req, precharge_req, array_write, cmd_refused;
   logic pattern_on, dq_valid;
   sprr_cmd_e cmd_code;
   logic [2:0] cmd_bank, arr_bank, arr_beat;
   logic [15:0] cmd_addr, arr_data, dq_out;
   logic [9:0] arr_col;
   logic [1:0] pattern_loc;
   int mismatches = 0, tests_run = 0;
   always #10 core_clk = ~core_clk;
   assign arr_data = {arr_col[6:0], arr_bank, arr_beat, 3'h5};
   sprr_ctrl_model ctrl_i (.core_clk(core_clk), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr));
   sprr_core sprr_core_i (.core_clk(core_clk), .rst_n(rst_n),
      .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .rd_latency(5'(LAT)),
      .lane_repeat(lane_repeat), .arr_data(arr_data), .arr_req(arr_req),
      .arr_bank(arr_bank), .arr_col(arr_col), .arr_beat(arr_beat),
      .precharge_req(precharge_req), .array_write(array_write),
      .cmd_refused(cmd_refused), .pattern_on(pattern_on),
      .pattern_loc(pattern_loc), .dq_out(dq_out), .dq_valid(dq_valid));
   // -----------------------------------------
   // Shared read and burst check
   // -----------------------------------------
   task automatic burst(input logic pat, input logic [1:0] loc,
      input int first, input int n, input logic [2:0] b, input logic a12,
      input logic a2, input logic ap, input logic [6:0] c);
      logic [7:0] by;
      logic [2:0] bt;
      logic [15:0] ex;
      ctrl_i.rd(b, a12, a2, ap, c);
      // Pulses stand in the cycle after the taking edge
      `CHK("arr_req", !pat, arr_req)
      `CHK("precharge_req", !pat && ap, precharge_req)
      for (int k = 1; k < LAT; k++) begin
         @(posedge core_clk);
         #1;
         `CHK("dq_valid early", 1'b0, dq_valid)
      end
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         #1;
         bt = 3'(first + i);
         by = (loc == SPRR_LOC_CAL) ? {8{SPRR_CAL_PAT[bt]}} : 8'h00;
         if (!lane_repeat) by = {7'h00, by[0]};
         `CHK("dq_valid", 1'b1, dq_valid)
         if (pat) begin
            `CHK("pattern beat", {by, by}, dq_out)
         end else begin
            ex = {c[3:0], a2, 2'b00, b, bt, 3'h5};
            `CHK("array beat", ex, dq_out)
         end
      end
      @(posedge core_clk);
      #1;
      `CHK("dq_valid end", 1'b0, dq_valid)
   endtask
   task automatic mode3(input logic en, input logic [1:0] loc);
      ctrl_i.mode_set_command(SPRR_MR3_SEL, {13'h0, en, loc});
      @(posedge core_clk);
      #1;
      `CHK("pattern_on", en, pattern_on)
      `CHK("pattern_loc", loc, pattern_loc)
   endtask
   // -----------------------------------------
   // Scenarios
   // -----------------------------------------
   task automatic t_pattern();
      mode3(1'b1, 2'b00);
      burst(1'b1, 2'b00, 0, 8, 3'h7, 1'b1, 1'b0, 1'b1, 7'h7F);
      $display("t_pattern done");
   endtask
   task automatic t_chop();
      lane_repeat = 1'b0;
      ctrl_i.mode_set_command(SPRR_MR0_SEL, {14'h0, SPRR_BL_OTF});
      burst(1'b1, 2'b00, 4, 4, 3'h2, 1'b0, 1'b1, 1'b0, 7'h11);
      burst(1'b1, 2'b00, 0, 4, 3'h2, 1'b0, 1'b0, 1'b1, 7'h22);
      burst(1'b1, 2'b00, 0, 8, 3'h2, 1'b1, 1'b0, 1'b0, 7'h33);
      ctrl_i.mode_set_command(SPRR_MR0_SEL, {14'h0, SPRR_BL_FIX4});
      burst(1'b1, 2'b00, 4, 4, 3'h1, 1'b1, 1'b1, 1'b0, 7'h44);
      ctrl_i.mode_set_command(SPRR_MR0_SEL, {14'h0, SPRR_BL_FIX8});
      lane_repeat = 1'b1;
      $display("t_chop done");
   endtask
   task automatic t_reserved();
      for (int l = 1; l < 4; l++) begin
         mode3(1'b1, 2'(l));
         burst(1'b1, 2'(l), 0, 8, 3'h0, 1'b1, 1'b0, 1'b0, 7'h0);
      end
      $display("t_reserved done");
   endtask
   task automatic t_refuse();
      sprr_cmd_e bad[5] = '{SPRR_WRITE, SPRR_ACT, SPRR_PRE, SPRR_REF,
                            SPRR_OTHER};
      foreach (bad[i]) begin
         ctrl_i.send(bad[i], 3'h1, 16'h0000);
         `CHK("cmd_refused", 1'b1, cmd_refused)
         `CHK("array_write on", 1'b0, array_write)
      end
      $display("t_refuse done");
   endtask
   task automatic t_normal();
      mode3(1'b0, 2'b00);
      burst(1'b0, 2'b00, 0, 8, 3'h5, 1'b1, 1'b1, 1'b1, 7'h2B);
      `CHK("arr_bank", 3'h5, arr_bank)
      `CHK("arr_col", {7'h2B, 3'b100}, arr_col)
      ctrl_i.send(SPRR_WRITE, 3'h1, 16'h0000);
      `CHK("array_write", 1'b1, array_write)
      // Frozen clock holds the pulse and takes no command
      clk_en = 1'b0;
      ctrl_i.send(SPRR_WRITE, 3'h1, 16'h0000);
      `CHK("array_write frozen", 1'b1, array_write)
      clk_en = 1'b1;
      @(posedge core_clk);
      #1;
      `CHK("array_write thaw", 1'b0, array_write)
      $display("t_normal done");
   endtask
   task automatic t_reset();
      mode3(1'b1, 2'b00);
      ctrl_i.rd(3'h0, 1'b1, 1'b0, 1'b0, 7'h0);
      repeat (LAT + 1) @(posedge core_clk);
      #1;
      rst_n = 1'b0;
      #2;
      `CHK("pattern_on rst", 1'b0, pattern_on)
      `CHK("dq_valid rst", 1'b0, dq_valid)
      repeat (3) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      ctrl_i.mode_on = 1'b0;
      burst(1'b0, 2'b00, 0, 8, 3'h3, 1'b1, 1'b0, 1'b0, 7'h15);
      $display("t_reset done");
   endtask
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      t_pattern();
      t_chop();
      t_reserved();
      t_refuse();
      t_normal();
      t_reset();
      wrap_up();
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      mismatches++;
      wrap_up();
   end
endmodule
`default_nettype wire
